/* File: verif/ipe_cpu_model.sv */
// core model: takes each presented request after a set delay
`timescale 1ns/10ps
module ipe_cpu_model (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       intRequest,
  input  wire logic [7:0] acceptDelay,
  output logic            cpuAccept
);
  logic [7:0] waitCnt_ff;

  // one-cycle accept pulse, only while a request is presented
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpuAccept  <= 1'b0;
      waitCnt_ff <= 8'h00;
    end else if (cpuAccept || !intRequest) begin
      cpuAccept  <= 1'b0;
      waitCnt_ff <= 8'h00;
    end else if (waitCnt_ff == acceptDelay) begin
      cpuAccept <= 1'b1;
    end else begin
      waitCnt_ff <= waitCnt_ff + 8'h01;
    end
  end
endmodule

/* File: verif/tb_top.sv */
// bench: register access, priority resolution and event codes
`timescale 1ns/10ps
module tb_top;
  import ipe_pkg::*;
  typedef struct {
    logic [5:0]  src;
    logic [4:0]  lvl;
    logic [11:0] prim;
    logic [11:0] sec;
  } ipe_row_t;

  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, cpuAccept, intRequest;
  logic [63:0] req = 64'h0;
  logic [3:0]  mask = 4'h0;
  logic [7:0]  acceptDelay = 8'h00;
  logic [4:0]  intLevel;
  logic [11:0] primary_event_code, secondary_event_code;
  int          failCount = 0, nCompared = 0;
  logic [15:0] cfg [5] = '{16'hedcb, 16'hfed0, 16'h4321, 16'hf765, 16'hcba9};
  // index 35 is the debug request, 36 the non-maskable one
  ipe_row_t    rows [37] = '{
    '{6'h00,5'h01,12'h3c0,12'h600}, '{6'h01,5'h02,12'h3a0,12'h620},
    '{6'h02,5'h03,12'h380,12'h640}, '{6'h03,5'h04,12'h360,12'h660},
    '{6'h04,5'h05,12'h340,12'h680}, '{6'h05,5'h06,12'h320,12'h6a0},
    '{6'h06,5'h0f,12'h200,12'h700}, '{6'h07,5'h07,12'h300,12'h720},
    '{6'h08,5'h0c,12'h260,12'h800}, '{6'h09,5'h0c,12'h260,12'h820},
    '{6'h0a,5'h0c,12'h260,12'h840}, '{6'h0b,5'h0c,12'h260,12'h860},
    '{6'h0c,5'h0b,12'h280,12'h880}, '{6'h0d,5'h0b,12'h280,12'h8a0},
    '{6'h0e,5'h0b,12'h280,12'h8c0}, '{6'h0f,5'h0b,12'h280,12'h8e0},
    '{6'h10,5'h0a,12'h2a0,12'h900}, '{6'h11,5'h0a,12'h2a0,12'h920},
    '{6'h12,5'h0a,12'h2a0,12'h940}, '{6'h13,5'h0a,12'h2a0,12'h960},
    '{6'h14,5'h09,12'h2c0,12'h980}, '{6'h15,5'h0e,12'h400,12'h400},
    '{6'h16,5'h0d,12'h420,12'h420}, '{6'h17,5'h0c,12'h440,12'h440},
    '{6'h18,5'h0c,12'h460,12'h460}, '{6'h19,5'h0b,12'h480,12'h480},
    '{6'h1a,5'h0b,12'h4a0,12'h4a0}, '{6'h1b,5'h0b,12'h4c0,12'h4c0},
    '{6'h1c,5'h0d,12'h4e0,12'h4e0}, '{6'h1d,5'h0d,12'h500,12'h500},
    '{6'h1e,5'h0d,12'h520,12'h520}, '{6'h1f,5'h0d,12'h540,12'h540},
    '{6'h20,5'h0f,12'h560,12'h560}, '{6'h21,5'h0e,12'h580,12'h580},
    '{6'h22,5'h0e,12'h5a0,12'h5a0}, '{6'h23,5'h0f,12'h5e0,12'h5e0},
    '{6'h24,5'h10,12'h1c0,12'h1c0}};

  always #50 ref_clk = ~ref_clk;

  ipe_core dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nmiRequest(req[36]), .debugRequest(req[35]), .srcRequest(req[34:0]),
    .cpuMaskLevel(mask), .cpuAccept(cpuAccept), .intRequest(intRequest),
    .intLevel(intLevel), .primary_event_code(primary_event_code),
    .secondary_event_code(secondary_event_code));

  ipe_cpu_model cpu (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .intRequest(intRequest), .acceptDelay(acceptDelay),
    .cpuAccept(cpuAccept));

  task automatic chk(input logic ok, input string msg);
    nCompared++;
    if (ok !== 1'b1) begin
      failCount++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // request held until pready is sampled high at an access edge
  task automatic apb(input logic wr, input logic [11:0] ad,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run(input logic [5:0] a, input logic [5:0] b,
                     input logic [3:0] m, input logic [4:0] lvl,
                     input logic [11:0] p, input logic [11:0] s);
    logic [63:0] v;
    logic [31:0] d;
    logic        e;
    int          n;
    v = 64'h0;
    v[a] = 1'b1;
    v[b] = 1'b1;
    n = 0;
    @(posedge ref_clk);
    mask <= m;
    req  <= v;
    @(posedge ref_clk);
    #1;
    while (cpuAccept !== 1'b1 && n < 16) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk((cpuAccept === 1'b1) == (lvl != 5'h00), "accept seen");
    chk(intLevel === lvl && intRequest === (lvl != 5'h00), "level");
    @(posedge ref_clk);
    req <= 64'h0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(primary_event_code === p && secondary_event_code === s, "codes");
    apb(1'b0, OffPrimCode, 32'h0, d, e);
    chk(d === {20'h0, p} && e === 1'b0, "primary code read");
    apb(1'b0, OffSecCode, 32'h0, d, e);
    chk(d === {20'h0, s} && e === 1'b0, "secondary code read");
  endtask

  task automatic all_zero;
    logic [31:0] d;
    logic        e;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0, d, e);
      chk(d === 32'h0, "value after reset");
    end
  endtask

  task automatic results;
    $display("compared %0d, failed %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #3_000_000;
    failCount++;
    results();
  end

  initial begin
    logic [31:0] d;
    logic        e;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    all_zero();
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 12'(4 * i), {16'hffff, cfg[i]}, d, e);
      apb(1'b0, 12'(4 * i), 32'h0, d, e);
      chk(d === {16'h0, cfg[i]}, "priority readback");
    end
    apb(1'b0, 12'h020, 32'h0, d, e);
    chk(e === 1'b1 && d === 32'h0, "unmapped read");
    foreach (rows[i]) begin
      acceptDelay <= i[0] ? 8'h05 : 8'h00;
      run(rows[i].src, 6'h3f, 4'h0, rows[i].lvl, rows[i].prim,
          rows[i].sec);
    end
    run(6'h08, 6'h0b, 4'h0, 5'h0c, 12'h260, 12'h800);
    run(6'h0f, 6'h0c, 4'h0, 5'h0b, 12'h280, 12'h880);
    run(6'h13, 6'h10, 4'h0, 5'h0a, 12'h2a0, 12'h900);
    run(6'h18, 6'h17, 4'h0, 5'h0c, 12'h440, 12'h440);
    run(6'h1b, 6'h19, 4'h0, 5'h0b, 12'h480, 12'h480);
    run(6'h1f, 6'h1c, 4'h0, 5'h0d, 12'h4e0, 12'h4e0);
    run(6'h22, 6'h21, 4'h0, 5'h0e, 12'h580, 12'h580);
    run(6'h17, 6'h08, 4'h0, 5'h0c, 12'h260, 12'h800);
    run(6'h20, 6'h06, 4'h0, 5'h0f, 12'h200, 12'h700);
    run(6'h20, 6'h23, 4'h0, 5'h0f, 12'h5e0, 12'h5e0);
    run(6'h23, 6'h24, 4'h0, 5'h10, 12'h1c0, 12'h1c0);
    run(6'h00, 6'h20, 4'h0, 5'h0f, 12'h560, 12'h560);
    run(6'h15, 6'h3f, 4'he, 5'h00, 12'h560, 12'h560);
    run(6'h23, 6'h3f, 4'hf, 5'h00, 12'h560, 12'h560);
    run(6'h24, 6'h3f, 4'hf, 5'h10, 12'h1c0, 12'h1c0);
    run(6'h20, 6'h3f, 4'he, 5'h0f, 12'h560, 12'h560);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    all_zero();
    run(6'h00, 6'h3f, 4'h0, 5'h00, 12'h000, 12'h000);
    results();
  end
endmodule

/* File: verilog/ipe_core.sv */
// interrupt priority resolver and event code generator with apb slave
// Operation
// R1 - every source gets its own event code
// R2 - programmable levels 0-15 in five registers
// R3 - reset clears all programmable levels
// R4 - ties resolved by fixed default order
// R5 - level-coded primary for range-coded sources
// R6 - level code h200 at 15, step h20
// R7 - nmi level 16, code h1c0 both
// R8 - debug level 15 fixed, code h5e0
// R9 - request lines 0-3 in register c
// R10 - lines 4-5, port groups in register d
// R11 - four transfer ends share e[15:12]
// R12 - infrared requests share e[11:8]
// R13 - fifo serial requests share e[7:4]
// R14 - converter end uses e[3:0], h980
// R15 - timers in register a, underflow over capture
// R16 - clock unit requests share a[3:0]
// R17 - basic serial requests share b[7:4]
// R18 - watchdog b[15:12], refresh pair b[11:8]
// R19 - present highest level, latch codes on accept
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module ipe_core
  import ipe_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ipe_pkg::AddrW-1:0] paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 nmiRequest,
  input  wire logic                 debugRequest,
  input  wire logic [ipe_pkg::NumSrc-1:0] srcRequest,
  input  wire logic [3:0]           cpuMaskLevel,
  input  wire logic                 cpuAccept,
  output logic                      intRequest,
  output logic      [4:0]           intLevel,
  output logic      [ipe_pkg::CodeW-1:0] primary_event_code,
  output logic      [ipe_pkg::CodeW-1:0] secondary_event_code
);
  import ipe_pkg::*;

  logic [15:0]      priority_reg_a_ff;
  logic [15:0]      priority_reg_b_ff;
  logic [15:0]      priority_reg_c_ff;
  logic [15:0]      priority_reg_d_ff;
  logic [15:0]      priority_reg_e_ff;
  logic [15:0]      selReg;
  logic [3:0]       srcLvl [NumSrc];
  logic [4:0]       bestLvl;
  logic [CodeW-1:0] bestPrim;
  logic [CodeW-1:0] bestSec;
  logic             bestValid;
  logic [CodeW-1:0] nxt_prim;
  logic [CodeW-1:0] nxt_sec;
  logic [4:0]       heldLvl_ff;
  logic [CodeW-1:0] heldPrim_ff;
  logic [CodeW-1:0] heldSec_ff;
  ipe_state_t       state_ff;
  logic             apbWrite;
  logic             apbRead;

  assign apbWrite = psel && penable && pwrite;
  assign apbRead  = psel && !penable && !pwrite;

  // apb registers; writes land on the access edge, zero wait states
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      priority_reg_a_ff <= PriReset; // [R3]
      priority_reg_b_ff <= PriReset; // [R3]
      priority_reg_c_ff <= PriReset; // [R3]
      priority_reg_d_ff <= PriReset; // [R3]
      priority_reg_e_ff <= PriReset; // [R3]
    end else if (apbWrite) begin
      unique case (paddr)
        OffPriA: priority_reg_a_ff <= pwdata[15:0]; // [R2]
        OffPriB: priority_reg_b_ff <= pwdata[15:0]; // [R2]
        OffPriC: priority_reg_c_ff <= pwdata[15:0]; // [R2]
        OffPriD: priority_reg_d_ff <= pwdata[15:0]; // [R2]
        OffPriE: priority_reg_e_ff <= pwdata[15:0]; // [R2]
        default: ;
      endcase
    end
  end

  // read data is prepared in setup so it is stable in the access phase
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        pslverr <= 1'b0;
        unique case (paddr)
          OffPriA:     prdata <= {16'h0000, priority_reg_a_ff};
          OffPriB:     prdata <= {16'h0000, priority_reg_b_ff};
          OffPriC:     prdata <= {16'h0000, priority_reg_c_ff};
          OffPriD:     prdata <= {16'h0000, priority_reg_d_ff};
          OffPriE:     prdata <= {16'h0000, priority_reg_e_ff};
          OffPrimCode: prdata <= {20'h00000, primary_event_code};
          OffSecCode:  prdata <= {20'h00000, secondary_event_code};
          OffStatus:   prdata <= {26'h0000000, intRequest, intLevel};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
      if (!apbRead && !(psel && !penable)) prdata <= prdata;
    end
  end

  // level field per source
  always_comb begin
    selReg = priority_reg_e_ff;
    for (int i = 0; i < NumSrc; i++) begin
      unique case (SrcReg[i])
        RegA:    selReg = priority_reg_a_ff; // [R15] [R16]
        RegB:    selReg = priority_reg_b_ff; // [R17] [R18]
        RegC:    selReg = priority_reg_c_ff; // [R9]
        RegD:    selReg = priority_reg_d_ff; // [R10]
        default: selReg = priority_reg_e_ff; // [R11] [R12] [R13] [R14]
      endcase
      srcLvl[i] = selReg[SrcNib[i]*4 +: 4];
    end
  end

  // strict > keeps the earliest in default order on ties
  always_comb begin
    bestValid = 1'b0;
    bestLvl   = 5'h00;
    bestPrim  = CodeReset;
    bestSec   = CodeReset;
    if (nmiRequest) begin
      bestValid = 1'b1; // [R7]
      bestLvl   = LvlNmi;
      bestPrim  = CodeNmi;
      bestSec   = CodeNmi;
    end else begin
      if (debugRequest) begin
        bestValid = 1'b1; // [R8]
        bestLvl   = LvlDebug;
        bestPrim  = CodeDebug;
        bestSec   = CodeDebug;
      end
      for (int i = 0; i < NumSrc; i++) begin
        if (srcRequest[i] && srcLvl[i] != 4'h0 &&
            {1'b0, srcLvl[i]} > bestLvl) begin // [R4]
          bestValid = 1'b1;
          bestLvl   = {1'b0, srcLvl[i]};
          bestSec   = SrcCode[i]; // [R1]
          if (SrcLvlCode[i])
            bestPrim = CodeLvl15 +
              CodeW'((LvlMax - {1'b0, srcLvl[i]}) * CodeLvlStep); // [R5] [R6]
          else
            bestPrim = SrcCode[i];
        end
      end
    end
    if (bestLvl <= {1'b0, cpuMaskLevel} && !nmiRequest) bestValid = 1'b0;
  end

  assign nxt_prim = heldPrim_ff;
  assign nxt_sec  = heldSec_ff;

  // request handshake with the core
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff    <= IPE_IDLE;
      intRequest  <= 1'b0;
      intLevel    <= 5'h00;
      heldLvl_ff  <= 5'h00;
      heldPrim_ff <= CodeReset;
      heldSec_ff  <= CodeReset;
    end else begin
      unique case (state_ff)
        IPE_IDLE, IPE_ACK: begin
          intRequest <= bestValid; // [R19]
          intLevel   <= bestValid ? bestLvl : 5'h00;
          heldPrim_ff <= bestPrim;
          heldSec_ff  <= bestSec;
          heldLvl_ff  <= bestLvl;
          state_ff   <= bestValid ? IPE_REQ : IPE_IDLE;
        end
        IPE_REQ: begin
          if (cpuAccept) begin
            intRequest <= 1'b0;
            intLevel   <= 5'h00;
            state_ff   <= IPE_ACK;
          end else begin
            intRequest  <= bestValid;
            intLevel    <= bestValid ? bestLvl : 5'h00;
            heldPrim_ff <= bestPrim;
            heldSec_ff  <= bestSec;
            heldLvl_ff  <= bestLvl;
            state_ff    <= bestValid ? IPE_REQ : IPE_IDLE;
          end
        end
      endcase
    end
  end

  // event registers latch on acceptance
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      primary_event_code   <= CodeReset;
      secondary_event_code <= CodeReset;
    end else if (state_ff == IPE_REQ && cpuAccept) begin
      primary_event_code   <= nxt_prim; // [R19]
      secondary_event_code <= nxt_sec;
    end
  end

  // checks on resolver, handshake and register file
  a_nmi_code: assert property ( // [R7]
    @(posedge ref_clk) disable iff (sys_rst)
    (state_ff == IPE_REQ && cpuAccept && heldLvl_ff == LvlNmi)
      |=> primary_event_code == CodeNmi && secondary_event_code == CodeNmi)
    else $error("nmi code wrong");

  a_debug_code: assert property ( // [R8]
    @(posedge ref_clk) disable iff (sys_rst)
    (state_ff == IPE_REQ && cpuAccept && heldSec_ff == CodeDebug)
      |=> primary_event_code == CodeDebug &&
          secondary_event_code == CodeDebug)
    else $error("debug code wrong");

  a_level_code: assert property ( // [R5] [R6]
    @(posedge ref_clk) disable iff (sys_rst)
    (state_ff == IPE_REQ && cpuAccept && heldSec_ff >= SrcCode[0])
      |=> primary_event_code == {3'h1, ~heldLvl_ff[3:0], 5'h00})
    else $error("level code mismatch");

  a_fixed_code: assert property ( // [R1] [R5]
    @(posedge ref_clk) disable iff (sys_rst)
    (state_ff == IPE_REQ && cpuAccept && heldSec_ff < SrcCode[0])
      |=> primary_event_code == secondary_event_code)
    else $error("fixed source code pair differs");

  a_sec_latched: assert property ( // [R1] [R19]
    @(posedge ref_clk) disable iff (sys_rst)
    (state_ff == IPE_REQ && cpuAccept)
      |=> secondary_event_code == $past(heldSec_ff))
    else $error("secondary code not latched");

  a_codes_hold: assert property ( // [R19]
    @(posedge ref_clk) disable iff (sys_rst)
    !(state_ff == IPE_REQ && cpuAccept)
      |=> $stable(primary_event_code) && $stable(secondary_event_code))
    else $error("event codes moved without accept");

  a_reset_levels: assert property ( // [R3]
    @(posedge ref_clk)
    $fell(sys_rst) |-> priority_reg_a_ff == PriReset &&
      priority_reg_b_ff == PriReset && priority_reg_c_ff == PriReset &&
      priority_reg_d_ff == PriReset && priority_reg_e_ff == PriReset)
    else $error("levels not cleared");

  a_write_lands: assert property ( // [R2]
    @(posedge ref_clk) disable iff (sys_rst)
    (apbWrite && paddr == OffPriC)
      |=> priority_reg_c_ff == $past(pwdata[15:0]))
    else $error("write lost");

  a_write_e_lands: assert property ( // [R2]
    @(posedge ref_clk) disable iff (sys_rst)
    (apbWrite && paddr == OffPriE)
      |=> priority_reg_e_ff == $past(pwdata[15:0]))
    else $error("write to register e lost");

  a_read_level: assert property ( // [R2]
    @(posedge ref_clk) disable iff (sys_rst)
    (psel && !penable && paddr == OffPriA)
      |=> prdata == {16'h0000, $past(priority_reg_a_ff)})
    else $error("level read back wrong");

  a_pready_access: assert property ( // [R2]
    @(posedge ref_clk) disable iff (sys_rst)
    (psel && !penable) |=> pready)
    else $error("no ready in access phase");

  a_unmapped_err: assert property ( // [R2]
    @(posedge ref_clk) disable iff (sys_rst)
    (psel && !penable && paddr > OffStatus)
      |=> pslverr && prdata == '0)
    else $error("unmapped access not refused");

  a_nmi_wins: assert property ( // [R7]
    @(posedge ref_clk) disable iff (sys_rst)
    (nmiRequest && state_ff != IPE_REQ)
      |=> intRequest && intLevel == LvlNmi)
    else $error("nmi not presented");

  a_debug_level: assert property ( // [R8]
    @(posedge ref_clk) disable iff (sys_rst)
    (debugRequest && !nmiRequest && state_ff != IPE_REQ &&
     {1'b0, cpuMaskLevel} < LvlDebug)
      |=> intRequest && intLevel == LvlDebug)
    else $error("debug not presented at fixed level");

  a_above_mask: assert property ( // [R19]
    @(posedge ref_clk) disable iff (sys_rst)
    intRequest |-> intLevel > {1'b0, $past(cpuMaskLevel)} ||
      intLevel == LvlNmi)
    else $error("request at or below mask");

  a_no_source: assert property ( // [R19]
    @(posedge ref_clk) disable iff (sys_rst)
    (!nmiRequest && !debugRequest && srcRequest == '0)
      |=> !intRequest)
    else $error("request with no source");

  a_accept_drop: assert property ( // [R19]
    @(posedge ref_clk) disable iff (sys_rst)
    (state_ff == IPE_REQ && cpuAccept)
      |=> !intRequest && intLevel == '0)
    else $error("request kept after accept");

  a_level_shown: assert property ( // [R19]
    @(posedge ref_clk) disable iff (sys_rst)
    intRequest |-> intLevel != '0)
    else $error("request shown without level");

  a_tie_order: assert property ( // [R4]
    @(posedge ref_clk) disable iff (sys_rst)
    (!nmiRequest && !debugRequest && srcRequest[8] && srcRequest[23] &&
     $countones(srcRequest) == 2 && state_ff != IPE_REQ &&
     priority_reg_a_ff[7:4] == priority_reg_e_ff[15:12] &&
     priority_reg_e_ff[15:12] > cpuMaskLevel)
      |=> heldSec_ff == SrcCode[8])
    else $error("tie order broken");

  a_dma_order: assert property ( // [R11]
    @(posedge ref_clk) disable iff (sys_rst)
    (!nmiRequest && !debugRequest && srcRequest[8] && srcRequest[11] &&
     $countones(srcRequest) == 2 && state_ff != IPE_REQ &&
     priority_reg_e_ff[15:12] > cpuMaskLevel)
      |=> heldSec_ff == SrcCode[8])
    else $error("transfer end order broken");

  a_capture_order: assert property ( // [R15]
    @(posedge ref_clk) disable iff (sys_rst)
    (!nmiRequest && !debugRequest && srcRequest[23] && srcRequest[24] &&
     $countones(srcRequest) == 2 && state_ff != IPE_REQ &&
     priority_reg_a_ff[7:4] > cpuMaskLevel)
      |=> heldSec_ff == SrcCode[23])
    else $error("timer underflow order broken");
endmodule

/* File: verilog/ipe_pkg.sv */
// package: register map, field positions, event codes, source indices
package ipe_pkg;
  localparam int          AddrW        = 12;
  localparam int          NumSrc       = 35;
  localparam int          LvlW         = 4;
  localparam int          CodeW        = 12;
  localparam logic [11:0] OffPriA      = 12'h000;
  localparam logic [11:0] OffPriB      = 12'h004;
  localparam logic [11:0] OffPriC      = 12'h008;
  localparam logic [11:0] OffPriD      = 12'h00c;
  localparam logic [11:0] OffPriE      = 12'h010;
  localparam logic [11:0] OffPrimCode  = 12'h014;
  localparam logic [11:0] OffSecCode   = 12'h018;
  localparam logic [11:0] OffStatus    = 12'h01c;
  localparam logic [15:0] PriReset     = 16'h0000;
  localparam logic [11:0] CodeNmi      = 12'h1c0;
  localparam logic [11:0] CodeDebug    = 12'h5e0;
  localparam logic [11:0] CodeLvl15    = 12'h200;
  localparam logic [11:0] CodeLvlStep  = 12'h020;
  localparam logic [11:0] CodeReset    = 12'h000;
  localparam logic [4:0]  LvlNmi       = 5'h10;
  localparam logic [4:0]  LvlDebug     = 5'h0f;
  localparam logic [4:0]  LvlMax       = 5'h0f;
  // field selectors: register index 0..4 (a..e), nibble index 0..3
  localparam logic [2:0]  RegA = 3'h0;
  localparam logic [2:0]  RegB = 3'h1;
  localparam logic [2:0]  RegC = 3'h2;
  localparam logic [2:0]  RegD = 3'h3;
  localparam logic [2:0]  RegE = 3'h4;
  localparam logic [2:0]  RegFixed = 3'h7;
  // programmable sources in default order; index 0 highest
  localparam logic [2:0] SrcReg [NumSrc] = '{
    RegC, RegC, RegC, RegC, RegD, RegD, RegD, RegD,
    RegE, RegE, RegE, RegE, RegE, RegE, RegE, RegE,
    RegE, RegE, RegE, RegE, RegE, RegA, RegA, RegA, RegA,
    RegA, RegA, RegA, RegB, RegB, RegB, RegB, RegB, RegB, RegB};
  localparam logic [1:0] SrcNib [NumSrc] = '{
    2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h3, 2'h2,
    2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h2, 2'h2, 2'h2,
    2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h3, 2'h2, 2'h1, 2'h1,
    2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h3, 2'h2, 2'h2};
  localparam logic [11:0] SrcCode [NumSrc] = '{
    12'h600, 12'h620, 12'h640, 12'h660, 12'h680, 12'h6a0,
    12'h700, 12'h720, 12'h800, 12'h820, 12'h840, 12'h860,
    12'h880, 12'h8a0, 12'h8c0, 12'h8e0, 12'h900, 12'h920,
    12'h940, 12'h960, 12'h980, 12'h400, 12'h420, 12'h440,
    12'h460, 12'h480, 12'h4a0, 12'h4c0, 12'h4e0, 12'h500,
    12'h520, 12'h540, 12'h560, 12'h580, 12'h5a0};
  // 1 = primary code follows the level, 0 = primary equals secondary
  localparam logic [NumSrc-1:0] SrcLvlCode = 35'h0_001f_ffff;
  typedef enum logic [2:0] {
    IPE_IDLE = 3'b001,
    IPE_REQ  = 3'b010,
    IPE_ACK  = 3'b100
  } ipe_state_t;
endpackage
